/* File: tb_top.sv */
// tb_top.sv: self-checking bench of the reference sequencer
// assumes the checker bind and host model are compiled first
`timescale 1ns/1ps
`include "vrs_regs.vh"
module tb_top;
  logic        clk_i, resetn_i, enable_i, fixed_i, ok_req, sel_i, reg_ok, cyc, stb, we;
  logic [1:0]  strap;
  logic [5:0]  pcode;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat;
  wire         hpok, serial_vid_clock, serial_vid_data, pg, mode, ack;
  wire  [7:0]  core, nb;
  wire  [31:0] dat_o;
  integer      n_errors, checks, seed, r;
  vrs_sequencer #(.SS_STEP_NS(100)) vrs_sequencer_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .enable_i(enable_i), .fixed_vid_enable_i(fixed_i),
    .host_power_ok_i(hpok), .serial_vid_clock_i(serial_vid_clock), .serial_vid_data_i(serial_vid_data),
    .interface_select_i(sel_i), .parallel_code_i(pcode), .planes_in_regulation_i(reg_ok),
    .core_ref_o(core), .northbridge_ref_o(nb), .planes_power_good_o(pg),
    .serial_code_mode_o(mode), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  vrs_host_model vrs_host_model_i (.clk_i(clk_i), .resetn_i(resetn_i), .pg_i(pg),
    .ok_req_i(ok_req), .strap_i(strap), .host_power_ok_o(hpok),
    .serial_vid_clock_o(serial_vid_clock), .serial_vid_data_o(serial_vid_data));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic [7:0] f_start(input fx, input [1:0] c);
    f_start = fx ? 8'h70 - {c, 4'h0} : 8'h58 - {c, 3'h0};
  endfunction
  function automatic [7:0] f_par(input [5:0] p);
    f_par = (p >= 6'd36) ? 8'd57 - {2'b00, p - 6'd36} : 8'd124 - {1'b0, p, 1'b0};
  endfunction
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    integer k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k >= 20) begin
      chk("ack", 1, 0);
      stop_test;
    end
  endtask
  task automatic settle(input logic [7:0] c, input logic [7:0] n, input logic p);
    integer k;
    k = 0;
    while ((core !== c || nb !== n || pg !== p) && k < 8000) begin
      @(posedge clk_i);
      k++;
    end
    chk("refs", {c, n, p}, {core, nb, pg});
    if (k >= 8000) stop_test;
  endtask
  initial begin
    seed = 80;
    n_errors = 0;
    checks = 0;
    {resetn_i, enable_i, fixed_i, ok_req, sel_i, cyc, stb, we} = 8'h00;
    reg_ok = 1'b1;
    strap = 2'h0;
    pcode = 6'h00;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      enable_i <= 1'b0;
      strap <= c[1:0];
      settle(8'h00, 8'h00, 1'b0);
      repeat (12) @(posedge clk_i);
      enable_i <= 1'b1;
      settle(f_start(1'b0, c[1:0]), f_start(1'b0, c[1:0]), 1'b1);
    end
    chk("mode", 1, mode);
    wb(1'b0, `VRS_ADR_START, 32'h0, 4'hf);
    chk("start", 32'h40, rdat);
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    chk("unmapped", 0, rdat);
    r = 8'h38 + ($random(seed) & 7);
    wb(1'b1, `VRS_ADR_CMD, 32'h300 | r, 4'hf);
    repeat (100) @(posedge clk_i);
    chk("early", 32'h4040, {core, nb});
    ok_req <= 1'b1;
    repeat (12) @(posedge clk_i);
    wb(1'b1, `VRS_ADR_CMD, 32'h300 | `VRS_SER_OFF, 4'h1);
    repeat (100) @(posedge clk_i);
    chk("sel", 32'h4040, {core, nb});
    wb(1'b1, `VRS_ADR_CMD, 32'h300 | r, 4'hf);
    settle(8'h7c - r[6:0], 8'h7c - r[6:0], 1'b1);
    wb(1'b1, `VRS_ADR_CMD, 32'h100 | `VRS_SER_OFF, 4'hf);
    settle(8'h00, 8'h7c - r[6:0], 1'b1);
    strap <= 2'h0;
    ok_req <= 1'b0;
    settle(8'h40, 8'h40, 1'b1);
    ok_req <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("hold", 32'h4040, {core, nb});
    reg_ok <= 1'b0;
    settle(8'h00, 8'h00, 1'b0);
    enable_i <= 1'b0;
    ok_req <= 1'b0;
    reg_ok <= 1'b1;
    fixed_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    for (int c = 0; c < 4; c++) begin
      strap <= c[1:0];
      enable_i <= 1'b1;
      settle(f_start(1'b1, c[1:0]), f_start(1'b1, c[1:0]), 1'b1);
    end
    enable_i <= 1'b0;
    settle(8'h00, 8'h00, 1'b0);
    fixed_i <= 1'b0;
    sel_i <= 1'b1;
    r = 36 + ($random(seed) & 15);
    pcode <= r[5:0];
    repeat (12) @(posedge clk_i);
    enable_i <= 1'b1;
    settle(f_par(r[5:0]), 8'h00, 1'b1);
    chk("mode", 0, mode);
    pcode <= 6'h3f;
    settle(8'h1e, 8'h00, 1'b1);
    stop_test;
  end
endmodule // tb_top

/* File: vrs_host_model.sv */
// vrs_host_model.sv: host processor and board straps facing the sequencer
// assumes bench requests change on clk_i rising edges
`timescale 1ns/1ps
module vrs_host_model (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       pg_i,
  input  wire       ok_req_i,
  input  wire [1:0] strap_i,
  output wire       host_power_ok_o,
  output wire       serial_vid_clock_o,
  output wire       serial_vid_data_o
);
  logic lclk, pg_seen;
  initial begin
    lclk = 1'b0;
    #37;
    forever #200 lclk = ~lclk;
  end
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i || !ok_req_i) pg_seen <= 1'b0;
    else if (pg_i) pg_seen <= 1'b1;
  end
  assign host_power_ok_o = ok_req_i & pg_seen;
  // link toggles only while the host talks, straps otherwise
  assign serial_vid_clock_o = ok_req_i ? lclk : strap_i[1];
  assign serial_vid_data_o = ok_req_i ? ~lclk : strap_i[0];
endmodule // vrs_host_model

/* File: vrs_regs.vh */
// vrs_regs.vh: offsets, fields, reset values and timing counts of the reference sequencer
// assumes a 20 MHz core clock and reference codes in 12.5 mV units
`ifndef VRS_REGS_VH
`define VRS_REGS_VH
`define VRS_CLK_NS        50
`define VRS_ADR_CMD       4'h0
`define VRS_ADR_STATUS    4'h4
`define VRS_ADR_START     4'h8
`define VRS_CMD_CODE_MSB  6
`define VRS_CMD_CORE_BIT  8
`define VRS_CMD_NB_BIT    9
`define VRS_REF_TOP       8'h7c
`define VRS_PAR_LOW_BASE  8'h5d
`define VRS_PAR_SPLIT     6'h24
`define VRS_SER_OFF       7'h7c
`define VRS_SLEW_STEP_NS  3846
`define VRS_SS_STEP_NS    1000
`define VRS_POR_CYCLES    4'h8
`define VRS_RESET_REF     8'h00
`endif

/* File: vrs_seq_checker.sv */
// vrs_seq_checker.sv: port timing checks of the reference sequencer
// assumes it is bound to vrs_sequencer
`timescale 1ns/1ps
module vrs_seq_checker #(
  parameter SS_STEP_NS = 1000
) (
  input wire       clk_i,
  input wire       resetn_i,
  input wire       enable_i,
  input wire       planes_in_regulation_i,
  input wire [7:0] core_ref_o,
  input wire [7:0] northbridge_ref_o,
  input wire       planes_power_good_o,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_off; !enable_i [*8]; endsequence
  sequence s_lost; !planes_in_regulation_i [*8]; endsequence
  chk_core_step: assert property ($changed(core_ref_o) |->
    (core_ref_o == $past(core_ref_o) + 8'h1 || core_ref_o == $past(core_ref_o) - 8'h1))
    else $error("core ref jumped");
  chk_nb_step: assert property ($changed(northbridge_ref_o) |->
    (northbridge_ref_o == $past(northbridge_ref_o) + 8'h1 ||
     northbridge_ref_o == $past(northbridge_ref_o) - 8'h1)) else $error("nb ref jumped");
  chk_core_hold: assert property ($changed(core_ref_o) |=> $stable(core_ref_o))
    else $error("core ref not held");
  chk_pg_enable: assert property (s_off |-> !planes_power_good_o)
    else $error("power good without enable");
  chk_pg_lost: assert property (s_lost |-> !planes_power_good_o)
    else $error("power good without regulation");
  chk_pg_target: assert property ($rose(planes_power_good_o) |-> core_ref_o != 8'h00)
    else $error("power good at zero ref");
  chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule // vrs_seq_checker
bind vrs_sequencer vrs_seq_checker #(.SS_STEP_NS(SS_STEP_NS)) vrs_seq_checker_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .enable_i(enable_i),
  .planes_in_regulation_i(planes_in_regulation_i), .core_ref_o(core_ref_o),
  .northbridge_ref_o(northbridge_ref_o), .planes_power_good_o(planes_power_good_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

/* File: vrs_sequencer.v */
// vrs_sequencer.v: reference target decode and soft-start / slew / power-down sequencer
// assumes pins are asynchronous to clk_i and software reaches registers over classic wishbone
//
// Operation
// [RL1] parallel code 100100 is 0.7125 V, steps down
// [RL2] fixed-vid low: pins give 1.1/1.0/0.9/0.8 V
// [RL3] start pins decoded only after power-on reset
// [RL4] enable rise latches start code for both planes
// [RL5] soft-start stair-steps both references to target
// [RL6] soft-start done and regulated raises power-good
// [RL7] enable fall drops power-good, ramps to zero
// [RL8] fixed-vid high: pins give 1.4/1.2/1.0/0.8 V
// [RL9] fixed mode keeps tracking strapped pins
// [RL10] host power-ok after power-good enables commands
// [RL11] set-vid command steps addressed planes
// [RL12] core plane off keeps power-good asserted
// [RL13] host keeps northbridge plane on meanwhile
// [RL14] host power-ok loss returns to held start
// [RL15] no start pin resampling during that return
// [RL16] power-ok return holds level, awaits command
// [RL17] power-good loss ramps both planes down
// [RL18] serial code 0 is 1.55 V, 7c-7f off
// [RL19] interface select latched at enable rise
// [RL20] target change slews at 3.25 mV/us
// [RL21] references hold; soft-start step period fixed
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "vrs_regs.vh"
module vrs_sequencer #(
  parameter SS_STEP_NS = `VRS_SS_STEP_NS
) (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        enable_i,
  input  wire        fixed_vid_enable_i,
  input  wire        host_power_ok_i,
  input  wire        serial_vid_clock_i,
  input  wire        serial_vid_data_i,
  input  wire        interface_select_i,
  input  wire [5:0]  parallel_code_i,
  input  wire        planes_in_regulation_i,
  output reg  [7:0]  core_ref_o,
  output reg  [7:0]  northbridge_ref_o,
  output reg         planes_power_good_o,
  output wire        serial_code_mode_o,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);
  localparam [3:0] ST_OFF  = 4'b0001;
  localparam [3:0] ST_SOFT = 4'b0010;
  localparam [3:0] ST_RUN  = 4'b0100;
  localparam [3:0] ST_DOWN = 4'b1000;
  localparam integer SLEW_CYC = (`VRS_SLEW_STEP_NS / `VRS_CLK_NS) < 1 ? 1 :
                                (`VRS_SLEW_STEP_NS / `VRS_CLK_NS);
  localparam integer SS_CYC   = (SS_STEP_NS + `VRS_CLK_NS - 1) / `VRS_CLK_NS < 1 ? 1 :
                                (SS_STEP_NS + `VRS_CLK_NS - 1) / `VRS_CLK_NS;
  localparam integer NPIN = 13;

  // three-flop synchronisers, change accepted once stages two and three agree
  wire [NPIN-1:0] pin_raw = {parallel_code_i, planes_in_regulation_i, interface_select_i,
                             serial_vid_data_i, serial_vid_clock_i, host_power_ok_i,
                             fixed_vid_enable_i, enable_i};
  reg  [NPIN-1:0] pin_s1_reg;
  reg  [NPIN-1:0] pin_s2_reg;
  reg  [NPIN-1:0] pin_s3_reg;
  reg  [NPIN-1:0] pin_reg;
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pin_s1_reg[g] <= 1'b0;
          pin_s2_reg[g] <= 1'b0;
          pin_s3_reg[g] <= 1'b0;
          pin_reg[g]    <= 1'b0;
        end else begin
          pin_s1_reg[g] <= pin_raw[g];
          pin_s2_reg[g] <= pin_s1_reg[g];
          pin_s3_reg[g] <= pin_s2_reg[g];
          if (pin_s2_reg[g] == pin_s3_reg[g]) begin
            pin_reg[g] <= pin_s3_reg[g];
          end
        end
      end
    end
  endgenerate
  // filtered pin levels
  wire       en_w    = pin_reg[0];
  wire       fixen_w = pin_reg[1];
  wire       hpok_w  = pin_reg[2];
  wire [1:0] strap_w = {pin_reg[3], pin_reg[4]};
  wire       sel_w   = pin_reg[5];
  wire       reg_ok_w = pin_reg[6];
  wire [5:0] par_w   = pin_reg[12:7];

  // start code decode: {clock, data} strap pins
  function [7:0] start_ref;
    input       fixed;
    input [1:0] code;
    begin
      case ({fixed, code})
        3'b000:  start_ref = 8'h58; // [RL2]
        3'b001:  start_ref = 8'h50;
        3'b010:  start_ref = 8'h48;
        3'b011:  start_ref = 8'h40;
        3'b100:  start_ref = 8'h70; // [RL8]
        3'b101:  start_ref = 8'h60;
        3'b110:  start_ref = 8'h50;
        default: start_ref = 8'h40;
      endcase
    end
  endfunction

  function [7:0] par_ref;
    input [5:0] code;
    begin
      if (code >= `VRS_PAR_SPLIT) begin
        par_ref = `VRS_PAR_LOW_BASE - {2'b00, code}; // [RL1]
      end else begin
        par_ref = `VRS_REF_TOP - {1'b0, code, 1'b0};
      end
    end
  endfunction

  function [7:0] ser_ref;
    input [6:0] code;
    begin
      if (code >= `VRS_SER_OFF) begin
        ser_ref = 8'h00; // [RL18]
      end else begin
        ser_ref = `VRS_REF_TOP - {1'b0, code};
      end
    end
  endfunction

  // one reference unit toward target, otherwise hold
  function [7:0] step_ref;
    input [7:0] cur;
    input [7:0] tgt;
    begin
      if (cur < tgt) begin
        step_ref = cur + 8'h01;
      end else if (cur > tgt) begin
        step_ref = cur - 8'h01;
      end else begin
        step_ref = cur;
      end
    end
  endfunction

  // sequencer state and targets
  reg  [3:0]  por_cnt_reg;
  reg  [3:0]  state_reg;
  reg         en_d_reg;
  reg         hpok_d_reg;
  reg         serial_mode_reg;
  reg         fixed_mode_reg;
  reg         cmd_armed_reg;
  reg  [7:0]  start_reg;
  reg  [7:0]  core_tgt_reg;
  reg  [7:0]  nb_tgt_reg;
  reg  [12:0] tick_reg;
  wire        por_done_w = (por_cnt_reg == `VRS_POR_CYCLES);
  wire        en_rise_w  = en_w & ~en_d_reg & por_done_w;
  wire        tick_w     = (state_reg == ST_SOFT) ? (tick_reg >= SS_CYC - 1)
                                                  : (tick_reg >= SLEW_CYC - 1);
  wire        at_tgt_w   = (core_ref_o == core_tgt_reg) && (northbridge_ref_o == nb_tgt_reg);
  wire [7:0]  live_start_w = start_ref(fixen_w, strap_w);
  wire        wb_req_w   = wb_cyc_i & wb_stb_i;
  wire        cmd_wr_w   = wb_req_w & wb_ack_o & wb_we_i & (wb_adr_i == `VRS_ADR_CMD) &
                           wb_sel_i[0] & wb_sel_i[1];
  wire [7:0]  cmd_ref_w  = ser_ref(wb_dat_i[`VRS_CMD_CODE_MSB:0]);
  wire        cmd_core_w = wb_dat_i[`VRS_CMD_CORE_BIT];
  wire        cmd_nb_w   = wb_dat_i[`VRS_CMD_NB_BIT];
  wire        cmd_go_w   = cmd_wr_w & cmd_armed_reg;
  wire        down_req_w = ~en_w | ~reg_ok_w;
  // status word seen over the register bus
  wire [31:0] status_w   = {8'h00, northbridge_ref_o, core_ref_o, state_reg,
                            cmd_armed_reg, fixed_mode_reg, serial_mode_reg,
                            planes_power_good_o};
  assign serial_code_mode_o = serial_mode_reg;

  // control: start code latch, mode latch and target selection
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_cnt_reg         <= 4'h0;
      state_reg           <= ST_OFF;
      en_d_reg            <= 1'b0;
      hpok_d_reg          <= 1'b0;
      serial_mode_reg     <= 1'b0;
      fixed_mode_reg      <= 1'b0;
      cmd_armed_reg       <= 1'b0;
      start_reg           <= `VRS_RESET_REF;
      core_tgt_reg        <= `VRS_RESET_REF;
      nb_tgt_reg          <= `VRS_RESET_REF;
      planes_power_good_o <= 1'b0;
    end else begin
      if (!por_done_w) begin
        por_cnt_reg <= por_cnt_reg + 4'h1;
      end
      en_d_reg   <= en_w;
      hpok_d_reg <= hpok_w;
      case (state_reg)
        ST_OFF: begin
          planes_power_good_o <= 1'b0;
          if (en_rise_w) begin
            serial_mode_reg <= ~sel_w; // [RL19]
            fixed_mode_reg  <= fixen_w;
            start_reg       <= live_start_w; // [RL3] [RL4]
            core_tgt_reg    <= sel_w ? par_ref(par_w) : live_start_w;
            nb_tgt_reg      <= sel_w ? 8'h00 : live_start_w;
            cmd_armed_reg   <= 1'b0;
            state_reg       <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          if (!en_w) begin
            core_tgt_reg <= 8'h00; // [RL7]
            nb_tgt_reg   <= 8'h00;
            state_reg    <= ST_DOWN;
          end else if (at_tgt_w && reg_ok_w) begin
            planes_power_good_o <= 1'b1; // [RL6]
            state_reg           <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (down_req_w) begin
            planes_power_good_o <= 1'b0; // [RL7] [RL17]
            core_tgt_reg        <= 8'h00;
            nb_tgt_reg          <= 8'h00;
            state_reg           <= ST_DOWN;
          end else if (!serial_mode_reg) begin
            core_tgt_reg <= par_ref(par_w);
          end else if (fixed_mode_reg || fixen_w) begin
            fixed_mode_reg <= fixen_w; // [RL9]
            start_reg      <= live_start_w;
            core_tgt_reg   <= live_start_w;
            nb_tgt_reg     <= live_start_w;
          end else if (!hpok_w) begin
            cmd_armed_reg <= 1'b0;
            core_tgt_reg  <= start_reg; // [RL14] [RL15]
            nb_tgt_reg    <= start_reg;
          end else if (!hpok_d_reg) begin
            cmd_armed_reg <= 1'b1; // [RL10] [RL16]
          end else if (cmd_go_w) begin
            if (cmd_core_w) begin
              core_tgt_reg <= cmd_ref_w; // [RL11] [RL12]
            end
            if (cmd_nb_w) begin
              nb_tgt_reg <= cmd_ref_w; // [RL11]
            end
          end
        end
        ST_DOWN: begin
          planes_power_good_o <= 1'b0;
          core_tgt_reg        <= 8'h00;
          nb_tgt_reg          <= 8'h00;
          if (at_tgt_w) begin
            state_reg <= ST_OFF;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  // reference stepping: one unit toward target per tick, otherwise hold
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_reg          <= 13'h0000;
      core_ref_o        <= `VRS_RESET_REF;
      northbridge_ref_o <= `VRS_RESET_REF;
    end else begin
      tick_reg <= tick_w ? 13'h0000 : tick_reg + 13'h0001;
      if (tick_w && (state_reg != ST_OFF)) begin
        core_ref_o        <= step_ref(core_ref_o, core_tgt_reg); // [RL5] [RL20] [RL21]
        northbridge_ref_o <= step_ref(northbridge_ref_o, nb_tgt_reg); // [RL5] [RL20]
      end
    end
  end

  // wishbone slave: ack one cycle after request, dropped the cycle after
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req_w & ~wb_ack_o;
      case (wb_adr_i)
        `VRS_ADR_STATUS: wb_dat_o <= status_w;
        `VRS_ADR_START:  wb_dat_o <= {24'h000000, start_reg};
        default:         wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule // vrs_sequencer
